/* File: rpsc_top.v */
`timescale 1ns/100ps
`default_nettype none
`include "rpsc_defines.vh"
module rpsc_top #(
  parameter CPU_RST_CYCLES = `RPSC_CPU_RST_CYCLES,
  parameter COMP_CYCLES = `RPSC_COMP_CYCLES,
  parameter HA_WIDTH = `RPSC_HA_WIDTH
) (
  // clock and reset
  input wire I_CLOCK,
  input wire I_SYS_RST,
  // power good, asynchronous pin
  input wire I_POWER_GOOD_IN,
  // host address lines as seen at the pads
  input wire [HA_WIDTH-1:0] I_HOST_ADDRESS_LINES,
  // processor reset, active low, open drain with termination
  output reg O_PROCESSOR_RESET_OUT_N,
  output reg O_PROCESSOR_RESET_OE,
  output reg O_PROCESSOR_RESET_TERM,
  // host bus pad control
  output reg O_HOST_ADDRESS_OE,
  output reg O_HOST_ADDRESS_TERM,
  output reg O_HOST_CTRL_OE,
  output reg O_HOST_CTRL_TERM,
  output reg O_POWER_ON_CONFIG_STATE,
  // captured straps
  output reg [HA_WIDTH-1:0] O_STRAP_CONFIG,
  output reg O_STRAP_VALID,
  // memory channels, index 0 is A, 1 is B
  output reg [1:0] O_MEM_BUS_OE,
  output reg [3:0] O_MEM_CLOCK_ENABLE_A,
  output reg [3:0] O_MEM_CLOCK_ENABLE_B,
  output reg [3:0] O_MEM_ON_DIE_TERM_A,
  output reg [3:0] O_MEM_ON_DIE_TERM_B,
  output reg [1:0] O_MEM_CKE_OE,
  // compensation pads
  output reg O_HOST_IMPEDANCE_COMP_PAD_OE,
  output reg O_MEM_IMPEDANCE_COMP_PAD_OE,
  output reg O_COMP_DONE,
  output reg O_CPU_RESET_DONE
);
  localparam [1:0] ST_RESET = 2'h0;
  localparam [1:0] ST_HOLD = 2'h1;
  localparam [1:0] ST_RUN = 2'h2;

  wire pg_s;
  wire [HA_WIDTH-1:0] ha_s;
  reg pg_d;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [31:0] cnt;
  reg [31:0] comp_cnt;
  // delay end, one cycle ahead of the release
  wire delay_done;
  // synchronized power good has just risen
  wire pg_rise;
  genvar ch;

  rpsc_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_pg (
    .i_clk(I_CLOCK),
    .i_rst(I_SYS_RST),
    .i_d(I_POWER_GOOD_IN),
    .o_q(pg_s)
  );
  rpsc_sync #(.WIDTH(HA_WIDTH), .RESET_VAL({HA_WIDTH{1'b1}})) u_ha (
    .i_clk(I_CLOCK),
    .i_rst(I_SYS_RST),
    .i_d(I_HOST_ADDRESS_LINES),
    .o_q(ha_s)
  );

  assign delay_done = (cnt >= CPU_RST_CYCLES - 1);
  assign pg_rise = pg_s & ~pg_d;

  always @* begin
    next_state = state;
    case (state)
      ST_RESET: next_state = ST_HOLD;
      ST_HOLD: begin
        if (delay_done)
          next_state = ST_RUN;
      end
      ST_RUN: next_state = ST_RUN;
      default: next_state = ST_RESET;
    endcase
  end

  // state clears at once on reset
  always @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      state <= ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // release delay: runs only while the processor reset is held
  always @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      cnt <= 32'h00000000;
    end else if (state == ST_HOLD) begin
      cnt <= cnt + 32'h00000001;
    end
  end

  // compensation cycle modelled as a fixed count that then stops
  always @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      comp_cnt <= 32'h00000000;
    end else if (comp_cnt < COMP_CYCLES) begin
      comp_cnt <= comp_cnt + 32'h00000001;
    end
  end

  // previous synchronized power good, for the edge detector
  always @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      pg_d <= 1'b0;
    end else begin
      pg_d <= pg_s;
    end
  end

  // straps: captured on the rising edge of power good
  always @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_STRAP_CONFIG <= {HA_WIDTH{1'b0}};
      O_STRAP_VALID <= 1'b0;
    end else if (pg_rise) begin
      O_STRAP_CONFIG <= ha_s;
      O_STRAP_VALID <= 1'b1;
    end
  end

  // processor reset: driven low until the delay ends
  always @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_PROCESSOR_RESET_OUT_N <= 1'b0;
      O_PROCESSOR_RESET_OE <= 1'b1;
      O_PROCESSOR_RESET_TERM <= 1'b0;
      O_CPU_RESET_DONE <= 1'b0;
    end else begin
      // release to terminated high, never strong high
      O_PROCESSOR_RESET_OUT_N <= 1'b0;
      O_PROCESSOR_RESET_OE <= (next_state != ST_RUN);
      O_PROCESSOR_RESET_TERM <= (next_state == ST_RUN);
      O_CPU_RESET_DONE <= (next_state == ST_RUN);
    end
  end

  // host address lines: straps in reset, power-on config after
  always @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_HOST_ADDRESS_OE <= 1'b0;
      O_HOST_ADDRESS_TERM <= 1'b1;
      O_POWER_ON_CONFIG_STATE <= 1'b0;
    end else begin
      O_HOST_ADDRESS_OE <= 1'b0;
      O_HOST_ADDRESS_TERM <= 1'b1;
      O_POWER_ON_CONFIG_STATE <= 1'b1;
    end
  end

  // host data, strobe and control lines: termination only
  always @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_HOST_CTRL_OE <= 1'b0;
      O_HOST_CTRL_TERM <= 1'b1;
    end else begin
      O_HOST_CTRL_OE <= 1'b0;
      O_HOST_CTRL_TERM <= 1'b1;
    end
  end

  // per channel: bus floats, clock enable pins driven low
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      always @(posedge I_CLOCK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
          O_MEM_BUS_OE[ch] <= 1'b0;
          O_MEM_CKE_OE[ch] <= 1'b1;
        end else begin
          O_MEM_BUS_OE[ch] <= 1'b0;
          O_MEM_CKE_OE[ch] <= 1'b1;
        end
      end
    end
  endgenerate

  // channel A clock enable and on-die termination held low
  always @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_MEM_CLOCK_ENABLE_A <= 4'h0;
      O_MEM_ON_DIE_TERM_A <= 4'h0;
    end else begin
      O_MEM_CLOCK_ENABLE_A <= 4'h0;
      O_MEM_ON_DIE_TERM_A <= 4'h0;
    end
  end

  // channel B clock enable and on-die termination held low
  always @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_MEM_CLOCK_ENABLE_B <= 4'h0;
      O_MEM_ON_DIE_TERM_B <= 4'h0;
    end else begin
      O_MEM_CLOCK_ENABLE_B <= 4'h0;
      O_MEM_ON_DIE_TERM_B <= 4'h0;
    end
  end

  // compensation pads stay floating before, during and after the cycle
  always @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_HOST_IMPEDANCE_COMP_PAD_OE <= 1'b0;
      O_MEM_IMPEDANCE_COMP_PAD_OE <= 1'b0;
      O_COMP_DONE <= 1'b0;
    end else begin
      O_HOST_IMPEDANCE_COMP_PAD_OE <= 1'b0;
      O_MEM_IMPEDANCE_COMP_PAD_OE <= 1'b0;
      O_COMP_DONE <= (comp_cnt >= COMP_CYCLES);
    end
  end
endmodule
`default_nettype wire

/* File: rpsc_defines.vh */
`ifndef RPSC_DEFINES_VH
`define RPSC_DEFINES_VH
`define RPSC_CLK_PERIOD_PS 5000
`define RPSC_CPU_RST_DELAY_US 1000
`define RPSC_CPU_RST_CYCLES ((`RPSC_CPU_RST_DELAY_US * 1000000) / `RPSC_CLK_PERIOD_PS)
`define RPSC_COMP_CYCLES 64
`define RPSC_HA_WIDTH 33
`endif

/* File: rpsc_sync.v */
`timescale 1ns/100ps
`default_nettype none
module rpsc_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input wire i_clk,
  input wire i_rst,
  input wire [WIDTH-1:0] i_d,
  output reg [WIDTH-1:0] o_q
);
  reg [WIDTH-1:0] meta;
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta <= RESET_VAL;
      o_q <= RESET_VAL;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule
`default_nettype wire

/* File: rpsc_top_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module rpsc_top_sva #(
  parameter CPU_RST_CYCLES = 20,
  parameter COMP_CYCLES = 64
) (
  input wire logic I_CLOCK, I_SYS_RST, O_HOST_CTRL_OE,
  input wire logic O_PROCESSOR_RESET_OE, O_PROCESSOR_RESET_TERM,
  input wire logic O_CPU_RESET_DONE, O_HOST_IMPEDANCE_COMP_PAD_OE,
  input wire logic O_PROCESSOR_RESET_OUT_N, O_HOST_ADDRESS_OE,
  input wire logic O_HOST_ADDRESS_TERM, O_HOST_CTRL_TERM,
  input wire logic O_POWER_ON_CONFIG_STATE, O_COMP_DONE,
  input wire logic O_MEM_IMPEDANCE_COMP_PAD_OE,
  input wire logic [3:0] O_MEM_CLOCK_ENABLE_A, O_MEM_CLOCK_ENABLE_B,
  input wire logic [3:0] O_MEM_ON_DIE_TERM_A, O_MEM_ON_DIE_TERM_B,
  input wire logic [1:0] O_MEM_BUS_OE, O_MEM_CKE_OE
);
  localparam int HI = CPU_RST_CYCLES + 2;
  localparam int CD = COMP_CYCLES + 1;
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_SYS_RST);
  sequence s_freed;
    $fell(O_PROCESSOR_RESET_OE);
  endsequence
  rst_drive_a: assert property (disable iff (0) I_SYS_RST |->
    O_PROCESSOR_RESET_OE && !O_PROCESSOR_RESET_TERM) else $error("undriven");
  hold_low_a: assert property ($fell(I_SYS_RST) |->
    O_PROCESSOR_RESET_OE [*8]) else $error("early release");
  late_rel_a: assert property ($fell(I_SYS_RST) |->
    ##HI !O_PROCESSOR_RESET_OE) else $error("late release");
  term_on_a: assert property (s_freed |->
    O_PROCESSOR_RESET_TERM && O_CPU_RESET_DONE) else $error("no term");
  no_strong_a: assert property (disable iff (0)
    !(O_PROCESSOR_RESET_OE && O_PROCESSOR_RESET_TERM)) else $error("fight");
  host_float_a: assert property (disable iff (0) !O_HOST_CTRL_OE)
    else $error("host driven");
  mem_quiet_a: assert property (disable iff (0) O_MEM_BUS_OE == 2'h0)
    else $error("mem driven");
  mem_low_a: assert property (disable iff (0) O_MEM_CKE_OE == 2'h3 &&
    (O_MEM_CLOCK_ENABLE_A | O_MEM_CLOCK_ENABLE_B | O_MEM_ON_DIE_TERM_A |
    O_MEM_ON_DIE_TERM_B) == 4'h0) else $error("mem level high");
  comp_tri_a: assert property (!O_HOST_IMPEDANCE_COMP_PAD_OE)
    else $error("comp driven");
  rst_level_a: assert property (disable iff (0)
    !O_PROCESSOR_RESET_OUT_N) else $error("reset level high");
  addr_term_a: assert property (disable iff (0) !O_HOST_ADDRESS_OE &&
    O_HOST_ADDRESS_TERM) else $error("addr not terminated");
  poc_entry_a: assert property ($fell(I_SYS_RST) |=>
    O_POWER_ON_CONFIG_STATE) else $error("no config state");
  ctrl_term_a: assert property (disable iff (0) O_HOST_CTRL_TERM)
    else $error("ctrl not terminated");
  comp_end_a: assert property ($fell(I_SYS_RST) |-> !O_COMP_DONE
    ##CD (O_COMP_DONE && !O_MEM_IMPEDANCE_COMP_PAD_OE))
    else $error("comp cycle wrong");
endmodule
`default_nettype wire

/* File: rpsc_partner.sv */
`timescale 1ns/100ps
`default_nettype none
module rpsc_partner (
  input wire logic i_clk,
  input wire logic i_ok,
  output var logic o_pg
);
  int c = 0;
  always @(posedge i_clk) c <= i_ok ? c + 1 : 0;
  // power good only after core power has been steady a while
  assign o_pg = c > 8;
endmodule
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; \
  $display("Error %0t %0h %0h", $time, a, e); end end
module testbench;
  logic clk = 0, rst = 0, ok = 0;
  logic [32:0] ha = '1;
  wire pg, oe, tm, pc, sv, dn;
  wire [32:0] cf;
  int n_fail = 0, tests_run = 0, n;
  always #2.5 clk = ~clk;
  rpsc_partner i_rpsc_partner (.i_clk(clk), .i_ok(ok), .o_pg(pg));
  rpsc_top #(.CPU_RST_CYCLES(20), .COMP_CYCLES(4)) i_rpsc_top (
    .I_CLOCK(clk), .I_SYS_RST(rst), .I_POWER_GOOD_IN(pg),
    .I_HOST_ADDRESS_LINES(ha), .O_PROCESSOR_RESET_OUT_N(),
    .O_PROCESSOR_RESET_OE(oe), .O_PROCESSOR_RESET_TERM(tm),
    .O_HOST_ADDRESS_OE(), .O_HOST_ADDRESS_TERM(), .O_HOST_CTRL_OE(),
    .O_HOST_CTRL_TERM(), .O_POWER_ON_CONFIG_STATE(pc),
    .O_STRAP_CONFIG(cf), .O_STRAP_VALID(sv), .O_MEM_BUS_OE(),
    .O_MEM_CLOCK_ENABLE_A(), .O_MEM_CLOCK_ENABLE_B(),
    .O_MEM_ON_DIE_TERM_A(), .O_MEM_ON_DIE_TERM_B(), .O_MEM_CKE_OE(),
    .O_HOST_IMPEDANCE_COMP_PAD_OE(), .O_MEM_IMPEDANCE_COMP_PAD_OE(),
    .O_COMP_DONE(), .O_CPU_RESET_DONE(dn));
  task close_out();
    $display("%0d compared %0d failed", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task t_rel();
    `CHK({oe, tm, pc, sv}, 4'h8)
    rst = 0;
    for (n = 0; n < 99 && oe === 1'b1; n++) @(negedge clk);
    `CHK(n inside {21, 22}, 1'b1)
    `CHK({tm, dn, pc}, 3'h7)
    if (n > 98) close_out();
    $display("release end");
  endtask
  task t_strap();
    ha = 33'h1_2345_6789;
    ok = 1;
    for (n = 0; n < 99 && sv !== 1'b1; n++) @(negedge clk);
    // lines released: termination pulls them high
    ha = '1;
    repeat (4) @(negedge clk);
    `CHK({sv, cf}, 34'h3_2345_6789)
    if (n > 98) close_out();
    $display("strap end");
  endtask
  task t_rerst();
    rst = 1;
    #1 `CHK({oe, tm, sv}, 3'h4)
    repeat (4) @(negedge clk);
    t_rel();
  endtask
  initial begin
    #1 rst = 1;
    repeat (4) @(negedge clk);
    t_rel();
    t_strap();
    t_rerst();
    close_out();
  end
endmodule
bind rpsc_top rpsc_top_sva #(.CPU_RST_CYCLES(CPU_RST_CYCLES),
  .COMP_CYCLES(COMP_CYCLES)) i_sva (.*);
`default_nettype wire
